/* bench/adt_detector_model.sv */
// behavioural signal-strength detector seen through the attenuator
`timescale 1ns/1ps
module adt_detector_model
(
    input wire logic [11:0] i_rssi_mv,
    input wire logic i_atten_on,
    output adt_pkg::adt_level_s o_level
);
    import adt_pkg::*;
    logic [11:0] eff;
    // attenuation drops the level by about 640 mV
    assign eff = (i_atten_on && i_rssi_mv > 12'h280) ? i_rssi_mv - 12'h280 : (i_atten_on ? 12'h000 : i_rssi_mv);
    assign o_level.above_upper = eff >= 12'h500;
    assign o_level.below_lower = eff < 12'h2A8;
endmodule // adt_detector_model

/* bench/adt_dwell_timer_props.sv */
// port assertions for the dwell timer
`timescale 1ns/1ps
module adt_dwell_timer_props
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire adt_pkg::adt_select_s i_select,
    input wire adt_pkg::adt_level_s i_level,
    input wire adt_pkg::adt_ctrl_s o_ctrl
);
    import adt_pkg::*;
    logic [31:0] below_cnt;
    logic [31:0] dwell_len;
    logic [7:0] above_hist;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    assign dwell_len = 32'h1 << (5'h09 + {1'b0, i_select, 1'b0});
    always_ff @(posedge i_ref_clk)
    begin
        below_cnt <= (i_rst || !i_level.below_lower) ? 32'h0 : below_cnt + 32'h1;
        above_hist <= i_rst ? 8'h00 : {above_hist[6:0], i_level.above_upper};
    end
    track_on_change_a: assert property ($changed(o_ctrl.atten_on) |-> o_ctrl.peak_track)
        else $error("no track pulse");
    track_single_a: assert property (o_ctrl.peak_track |=> !o_ctrl.peak_track)
        else $error("long track pulse");
    track_cause_a: assert property (o_ctrl.peak_track |-> $changed(o_ctrl.atten_on))
        else $error("stray track pulse");
    code_off_a: assert property ((i_select == 3'h0)[*8] |-> !o_ctrl.atten_on)
        else $error("atten while off");
    upper_atten_a: assert property ((i_level.above_upper && i_select != 3'h0)[*5] |-> ##[0:2] o_ctrl.atten_on)
        else $error("no attack");
    rise_cause_a: assert property ($rose(o_ctrl.atten_on) |-> above_hist != 8'h00 && i_select != 3'h0)
        else $error("attack without cause");
    dwell_len_a: assert property ($fell(o_ctrl.atten_on) && i_select != 3'h0 |->
        below_cnt >= dwell_len && below_cnt <= dwell_len + 32'hC)
        else $error("bad dwell");
    restart_hold_a: assert property ($fell(i_level.below_lower) && o_ctrl.atten_on && i_select != 3'h0 &&
        below_cnt < dwell_len |=> o_ctrl.atten_on[*8])
        else $error("early release");
endmodule // adt_dwell_timer_props
bind adt_dwell_timer adt_dwell_timer_props u_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_select(i_select), .i_level(i_level), .o_ctrl(o_ctrl));

/* bench/adt_dwell_timer_tb.sv */
// self-checking bench for the dwell timer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
    $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module adt_dwell_timer_tb;
    import adt_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    adt_select_s i_select = 3'h0;
    logic [11:0] rssi = 12'h000;
    adt_level_s i_level;
    adt_ctrl_s o_ctrl;
    int fails = 0;
    int num_checks = 0;
    always #25 i_ref_clk = ~i_ref_clk;
    adt_detector_model det (.i_rssi_mv(rssi), .i_atten_on(o_ctrl.atten_on), .o_level(i_level));
    adt_dwell_timer dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_select(i_select), .i_level(i_level),
        .o_ctrl(o_ctrl));
    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #5;
    endtask
    task automatic stop_test();
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_atten(input logic v, output int n);
        n = 0;
        while (o_ctrl.atten_on !== v && n < 40000)
        begin
            step(1);
            n++;
        end
        if (n >= 40000)
        begin
            fails++;
            stop_test();
        end
    endtask
    task automatic t_disabled();
        rssi = 12'h5DC;
        step(40);
        `CHK("off", 1'b0, o_ctrl.atten_on)
        rssi = 12'h12C;
        step(20);
    endtask
    // attack, track pulse and dwell length of one code against 2^k
    task automatic t_dwell(input logic [2:0] code, input int k);
        int n;
        i_select = code;
        step(10);
        rssi = 12'h5DC;
        wait_atten(1'b1, n);
        `CHK("attack", 1'b1, n <= 8)
        `CHK("track on", 1'b1, o_ctrl.peak_track)
        step(TRACK_PULSE_CYCLES);
        `CHK("track off", 1'b0, o_ctrl.peak_track)
        rssi = 12'h12C;
        wait_atten(1'b0, n);
        `CHK("dwell", 1'b1, n >= (1 << k) && n <= (1 << k) + 12)
        `CHK("track drop", 1'b1, o_ctrl.peak_track)
        step(10);
    endtask
    task automatic t_restart();
        int n;
        i_select = 3'h1;
        rssi = 12'h5DC;
        wait_atten(1'b1, n);
        rssi = 12'h12C;
        step(1000);
        // between thresholds while attenuated: count must be dropped
        rssi = 12'h5DC;
        step(3000);
        `CHK("held", 1'b1, o_ctrl.atten_on)
        rssi = 12'h12C;
        wait_atten(1'b0, n);
        `CHK("restart", 1'b1, n >= 2048 && n <= 2060)
    endtask
    // code zero in mid-dwell must drop the attenuator within 8 cycles
    task automatic t_abort();
        int n;
        i_select = 3'h1;
        rssi = 12'h5DC;
        wait_atten(1'b1, n);
        rssi = 12'h12C;
        step(100);
        i_select = 3'h0;
        step(8);
        `CHK("abort", 1'b0, o_ctrl.atten_on)
    endtask
    initial
    begin
        step(3);
        `CHK("rst", RST_ATTEN, o_ctrl.atten_on)
        i_rst = 1'b0;
        t_disabled();
        // odd exponents as a designer would pick them for short dwells
        t_dwell(3'h1, 11);
        t_dwell(3'h2, 13);
        t_dwell(3'h3, 15);
        t_restart();
        t_abort();
        stop_test();
    end
endmodule // adt_dwell_timer_tb

/* core/adt_dwell_timer.sv */
// gain-control dwell timer: attenuator sequencing with programmable hold
`timescale 1ns/1ps

module adt_dwell_timer
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire adt_pkg::adt_select_s i_select,
    input wire adt_pkg::adt_level_s i_level,
    output adt_pkg::adt_ctrl_s o_ctrl
);
    import adt_pkg::*;

    typedef struct packed {
        adt_state_e fsm;
        logic [CNT_W-1:0] count;
        logic [2:0] code;
        logic atten_on;
        logic peak_track;
        logic [3:0] track_left;
    } adt_core_s;

    adt_core_s state_reg;
    adt_core_s state_next;

    // one synchroniser per select pin; their count is the carrier's width, not the stage count
    localparam int SEL_W = $bits(adt_select_s);
    // the track request is held this many cycles after its first; the peak detectors stretch it further
    localparam logic [3:0] TRACK_LEFT_START = 4'(TRACK_PULSE_CYCLES - 1);

    // ****************************************
    // internal signals
    // ****************************************
    logic [SEL_W-1:0] pins_raw;
    logic [SEL_W-1:0] pins_sync;
    logic above_sync;
    logic below_sync;
    logic [4:0] exponent;
    logic [CNT_W-1:0] terminal;
    logic code_off;
    logic dwell_done;
    logic level_back;

    // ****************************************
    // pin synchronisers
    // ****************************************
    assign pins_raw = {i_select.hold_select_msb, i_select.hold_select_mid, i_select.hold_select_lsb};

    genvar gi;
    generate
        for (gi = 0; gi < SEL_W; gi++)
        begin : g_sel_sync
            adt_sync u_sync
            (
                .i_ref_clk(i_ref_clk),
                .i_rst(i_rst),
                .i_async(pins_raw[gi]),
                .o_level(pins_sync[gi])
            );
        end
    endgenerate

    // comparator outputs come from the analog detector, so they are synchronised too
    adt_sync u_sync_above
    (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async(i_level.above_upper),
        .o_level(above_sync)
    );

    adt_sync u_sync_below
    (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async(i_level.below_lower),
        .o_level(below_sync)
    );

    // ****************************************
    // dwell length decode
    // ****************************************
    // one exponent per code, rising in steps of two; code zero never reaches the counter
    always_comb
    begin
        unique case (state_reg.code)
            3'h0: exponent = EXP_MIN;
            3'h1: exponent = EXP_MIN;
            3'h2: exponent = EXP_MIN + EXP_STEP;
            3'h3: exponent = EXP_MIN + 5'h02 * EXP_STEP;
            3'h4: exponent = EXP_MIN + 5'h03 * EXP_STEP;
            3'h5: exponent = EXP_MIN + 5'h04 * EXP_STEP;
            3'h6: exponent = EXP_MIN + 5'h05 * EXP_STEP;
            3'h7: exponent = EXP_MIN + 5'h06 * EXP_STEP;
        endcase
    end
    // the count runs 0 .. 2^K-1, so expiry lands exactly 2^K clocks after ADT_LOW_DWELL is entered
    assign terminal = CNT_W'((25'h0000001 << exponent) - 25'h0000001);

    // ****************************************
    // sequencing conditions
    // ****************************************
    assign code_off = (state_reg.code == CODE_OFF);
    // >= rather than ==: a code shortened in mid-dwell must not leave the count running past its end
    assign dwell_done = (state_reg.count >= terminal);
    // the comparator result is already filtered, so one low sample ends the dwell
    assign level_back = !below_sync;

    // ****************************************
    // sequencing
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        // the code register adds one stage so that the decode sees a single settled value
        state_next.code = pins_sync;
        state_next.peak_track = 1'b0;
        if (code_off)
        begin
            // disabled: hold high gain, abandon any dwell in progress
            state_next.fsm = ADT_HIGH_GAIN;
            state_next.atten_on = 1'b0;
            state_next.count = CNT_RST;
        end
        else
        begin
            unique case (state_reg.fsm)
                ADT_HIGH_GAIN:
                begin
                    // full gain; only the upper comparator matters here
                    if (above_sync)
                    begin
                        state_next.fsm = ADT_LOW_HOLD;
                        state_next.atten_on = 1'b1;
                    end
                end
                ADT_LOW_HOLD:
                begin
                    // attenuated, waiting for the level to sink below the low threshold
                    if (below_sync)
                    begin
                        state_next.fsm = ADT_LOW_DWELL;
                        state_next.count = CNT_RST;
                    end
                end
                ADT_LOW_DWELL:
                begin
                    // counting the hold; the low comparator must stay set throughout
                    if (level_back)
                    begin
                        // level recovered: count abandoned, restarts at next drop
                        state_next.fsm = ADT_LOW_HOLD;
                        state_next.count = CNT_RST;
                    end
                    else if (dwell_done)
                    begin
                        state_next.fsm = ADT_HIGH_GAIN;
                        state_next.atten_on = 1'b0;
                        state_next.count = CNT_RST;
                    end
                    else
                    begin
                        state_next.count = state_reg.count + 24'h000001;
                    end
                end
                default:
                begin
                    // the unused state code falls back to high gain rather than locking up
                    state_next.fsm = ADT_HIGH_GAIN;
                    state_next.atten_on = 1'b0;
                    state_next.count = CNT_RST;
                end
            endcase
        end
        // a change of gain (re)starts the track request, so back-to-back changes merge into one
        if (state_next.atten_on != state_reg.atten_on)
        begin
            state_next.peak_track = 1'b1;
            state_next.track_left = TRACK_LEFT_START;
        end
        else if (state_reg.track_left != 4'h0)
        begin
            state_next.peak_track = 1'b1;
            state_next.track_left = state_reg.track_left - 4'h1;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            state_reg.fsm <= ADT_HIGH_GAIN;
            state_reg.count <= CNT_RST;
            state_reg.code <= CODE_OFF;
            state_reg.atten_on <= RST_ATTEN;
            state_reg.peak_track <= 1'b0;
            state_reg.track_left <= 4'h0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_ctrl.atten_on = state_reg.atten_on;
    assign o_ctrl.peak_track = state_reg.peak_track;
endmodule // adt_dwell_timer

/* core/adt_pkg.sv */
// package of constants and carrier types for the gain-control dwell timer
package adt_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned REF_CLK_HZ = 20000000;
    localparam int unsigned REF_CLK_PERIOD_NS = 50;
    localparam int CNT_W = 24;
    localparam logic [4:0] EXP_MIN = 5'h0B;
    localparam logic [4:0] EXP_STEP = 5'h02;
    localparam logic [2:0] CODE_OFF = 3'h0;
    localparam int SYNC_STAGES = 3;
    localparam int TRACK_PULSE_CYCLES = 1;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
    localparam logic RST_ATTEN = 1'b0;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        ADT_HIGH_GAIN,
        ADT_LOW_HOLD,
        ADT_LOW_DWELL
    } adt_state_e;

    typedef struct packed {
        logic hold_select_msb;
        logic hold_select_mid;
        logic hold_select_lsb;
    } adt_select_s;

    typedef struct packed {
        logic above_upper;
        logic below_lower;
    } adt_level_s;

    typedef struct packed {
        logic atten_on;
        logic peak_track;
    } adt_ctrl_s;

endpackage

/* core/adt_sync.sv */
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module adt_sync
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_async,
    output logic o_level
);
    import adt_pkg::*;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] pipe;
        logic level;
    } adt_sync_s;

    adt_sync_s state_reg;
    adt_sync_s state_next;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.pipe = {state_reg.pipe[SYNC_STAGES-2:0], i_async};
        // stage 0 is only read by stage 1; stages 1 and 2 must agree
        if (state_reg.pipe[1] == state_reg.pipe[2])
        begin
            state_next.level = state_reg.pipe[2];
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign o_level = state_reg.level;
endmodule // adt_sync
